// ==== design/uart_async_receiver.sv ====
// Notes on behaviour
// - Line sampled on a sixteen-times tick; shift register advances once per bit.
// - Finished characters go straight into a two-entry FIFO.
// - Reception runs only with receive enable, port enable, and synchronous mode off.
// - Port enable makes the receive pin input and forces the transmit pin output.
// - Start bit rechecked at half bit; if high, abandon silently and rehunt.
// - Data bits sampled at bit centre by majority vote and shifted in.
// - Stop position sampled; low sets that character's framing error, high clears it.
// - After the stop sample the character is pushed and the flag rises.
// - Flag is high exactly while enabled and the FIFO is non-empty; read-only.
// - Interrupt request needs receive, peripheral and global enables; flag ignores them.
// - Reading receive data returns and pops the oldest character.
// - Each entry keeps its framing error; status shows the oldest entry's bit.
// - Port disable clears framing status; receive disable does not; no interrupt.
// - A framing error does not stop reception.
// - Third character into a full FIFO sets overrun and blocks further reception.
// - Overrun clears only by clearing receive enable or port enable.
// - Nine-bit mode shifts nine bits; the ninth of the oldest entry is readable.
// - With address detection in nine-bit mode only ninth-bit-set characters are queued.
`timescale 1ns/1ps
module uart_async_receiver
  import uart_rx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        baudTick16,
  input  wire logic        receivePinIn,
  output logic             receivePinOe,
  output logic             transmitPinOe,
  input  wire logic        transmitDirBit,
  input  wire logic        transmitPortLatch,
  input  wire logic        transmitSerialOut,
  output logic             transmitPinOut,
  output logic             receiveInterruptFlag,
  output logic             receiveIrq
);

  logic [31:0] rxStatus_ff;
  logic [31:0] intCtrl_ff;
  logic [31:0] txStatus_ff;
  rx_state_e   state_ff;
  rx_state_e   nxt_state;
  logic [3:0]  tickCnt_ff;
  logic [3:0]  bitCnt_ff;
  logic [1:0]  votes_ff;
  logic [8:0]  shift_ff;
  logic        overrun_ff;
  logic        lineD_ff;
  logic        rxActive;
  logic        portEn;
  logic        nineBit;
  logic        access;
  logic        wrEn;
  logic        rdData;
  logic        bitDone;
  logic        voted;
  logic        charDone;
  logic        pushOk;
  logic        fifoFlush;
  logic        fifoNotEmpty;
  logic        fifoFull;
  rx_entry_s   pushEntry;
  rx_entry_s   topEntry;
  logic [8:0]  assembled;

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign portEn   = rxStatus_ff[PORTEN_POS];
  assign nineBit  = rxStatus_ff[NINE_POS];
  assign rxActive = rxStatus_ff[RXEN_POS] && portEn && !txStatus_ff[SYNC_POS];

  // Pin steering: receive pin never driven while enabled, transmit pin forced out.
  assign receivePinOe   = portEn ? 1'b0 : 1'b0;
  assign transmitPinOe  = portEn ? 1'b1 : !transmitDirBit;
  assign transmitPinOut = portEn ? transmitSerialOut : transmitPortLatch;

  // APB slave: zero-wait, every access answers in its access phase.
  assign access  = psel && penable;
  assign pready  = access;
  assign wrEn    = access && pwrite;
  assign rdData  = access && !pwrite && hit(paddr, RX_DATA_OFF);
  assign pslverr = access && !(hit(paddr, RX_STATUS_OFF) || hit(paddr, RX_DATA_OFF)
                   || hit(paddr, INT_CTRL_OFF) || hit(paddr, TX_STATUS_OFF));

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      unique case (1'b1)
        hit(paddr, RX_STATUS_OFF): prdata <= {23'h000000, receiveInterruptFlag, portEn, nineBit, 1'b0,
                                              rxStatus_ff[RXEN_POS], rxStatus_ff[ADDR_POS],
                                              topEntry.frameErr && fifoNotEmpty, overrun_ff,
                                              topEntry.data[8] && fifoNotEmpty};
        hit(paddr, RX_DATA_OFF):   prdata <= {24'h000000, fifoNotEmpty ? topEntry.data[7:0] : 8'h00};
        hit(paddr, INT_CTRL_OFF):  prdata <= intCtrl_ff;
        hit(paddr, TX_STATUS_OFF): prdata <= txStatus_ff;
        default:                   prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Only control bits are writable; status fields are rebuilt on read.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxStatus_ff <= RX_STATUS_RST;
      intCtrl_ff  <= INT_CTRL_RST;
      txStatus_ff <= TX_STATUS_RST;
    end
    else if (wrEn)
    begin
      if (hit(paddr, RX_STATUS_OFF))
      begin
        rxStatus_ff <= pwdata & ((32'h1 << PORTEN_POS) | (32'h1 << NINE_POS)
                       | (32'h1 << RXEN_POS) | (32'h1 << ADDR_POS));
      end
      if (hit(paddr, INT_CTRL_OFF))
      begin
        intCtrl_ff <= pwdata & 32'h0000_0007;
      end
      if (hit(paddr, TX_STATUS_OFF))
      begin
        txStatus_ff <= pwdata & (32'h1 << SYNC_POS);
      end
    end
  end

  // Line is taken as synchronous; one register gives the edge detector its history.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lineD_ff <= 1'b1;
    end
    else if (baudTick16)
    begin
      lineD_ff <= receivePinIn;
    end
  end

  assign bitDone = baudTick16 && (tickCnt_ff == LAST_TICK);
  // Two stored samples and the live line at the shift tick sit at the bit centre.
  assign voted   = majority({receivePinIn, votes_ff});

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
        if (baudTick16 && lineD_ff && !receivePinIn && !overrun_ff)
        begin
          nxt_state = ST_START;
        end
      ST_START:
        if (baudTick16 && tickCnt_ff == HALF_BIT)
        begin
          nxt_state = receivePinIn ? ST_IDLE : ST_DATA;
        end
      ST_DATA:
        if (bitDone && bitCnt_ff == (nineBit ? 4'h8 : 4'h7))
        begin
          nxt_state = ST_STOP;
        end
      ST_STOP:
        if (bitDone)
        begin
          nxt_state = ST_IDLE;
        end
    endcase
    if (!rxActive)
    begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Tick counter restarts at the half-bit point so later counts land at bit centres.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tickCnt_ff <= 4'h0;
    end
    else if (state_ff == ST_IDLE || (state_ff == ST_START && baudTick16 && tickCnt_ff == HALF_BIT))
    begin
      tickCnt_ff <= 4'h0;
    end
    else if (baudTick16)
    begin
      tickCnt_ff <= tickCnt_ff + 4'h1;
    end
  end

  // Two samples just before the bit centre feed the vote at the shift tick of each bit.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      votes_ff <= 2'b11;
    end
    else if (baudTick16 && (state_ff == ST_DATA || state_ff == ST_STOP))
    begin
      if (tickCnt_ff == VOTE_A)
      begin
        votes_ff[0] <= receivePinIn;
      end
      if (tickCnt_ff == VOTE_B)
      begin
        votes_ff[1] <= receivePinIn;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_ff  <= 9'h000;
      bitCnt_ff <= 4'h0;
    end
    else if (state_ff != ST_DATA)
    begin
      bitCnt_ff <= 4'h0;
    end
    else if (bitDone)
    begin
      shift_ff  <= {voted, shift_ff[8:1]};
      bitCnt_ff <= bitCnt_ff + 4'h1;
    end
  end

  // LSB-first shift leaves an 8-bit character one place high.
  assign assembled = nineBit ? shift_ff : {1'b0, shift_ff[8:1]};
  assign charDone  = (state_ff == ST_STOP) && bitDone && rxActive;
  assign pushOk    = charDone && !overrun_ff && !fifoFull
                     && (!(rxStatus_ff[ADDR_POS] && nineBit) || assembled[8]);
  assign pushEntry = '{frameErr: !voted, data: assembled};
  assign fifoFlush = !portEn;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      overrun_ff <= 1'b0;
    end
    else if (!rxStatus_ff[RXEN_POS] || !portEn)
    begin
      overrun_ff <= 1'b0;
    end
    else if (charDone && fifoFull)
    begin
      overrun_ff <= 1'b1;
    end
  end

  rx_char_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .flush    (fifoFlush),
    .push     (pushOk),
    .pushEntry(pushEntry),
    .pop      (rdData),
    .topEntry (topEntry),
    .notEmpty (fifoNotEmpty),
    .full     (fifoFull)
  );

  assign receiveInterruptFlag = rxStatus_ff[RXEN_POS] && portEn && fifoNotEmpty;
  assign receiveIrq = receiveInterruptFlag && intCtrl_ff[RXIE_POS]
                      && intCtrl_ff[PERIE_POS] && intCtrl_ff[GLOBIE_POS];

endmodule // uart_async_receiver

// ==== design/uart_rx_pkg.sv ====
package uart_rx_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] RX_STATUS_OFF  = 8'h00;
  localparam logic [7:0] RX_DATA_OFF    = 8'h04;
  localparam logic [7:0] INT_CTRL_OFF   = 8'h08;
  localparam logic [7:0] TX_STATUS_OFF  = 8'h0c;

  // Field positions in the receive status register.
  localparam int NINTH_POS   = 0;
  localparam int OVERRUN_POS = 1;
  localparam int FRAME_POS   = 2;
  localparam int ADDR_POS    = 3;
  localparam int RXEN_POS    = 4;
  localparam int NINE_POS    = 6;
  localparam int PORTEN_POS  = 7;
  localparam int FLAG_POS    = 8;

  // Field positions in the interrupt control register.
  localparam int RXIE_POS    = 0;
  localparam int PERIE_POS   = 1;
  localparam int GLOBIE_POS  = 2;

  // Field position of the synchronous-mode bit in the transmit status register.
  localparam int SYNC_POS    = 4;

  localparam logic [31:0] RX_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] INT_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] TX_STATUS_RST = 32'h0000_0000;

  // Oversampling: ticks per bit, half bit, and the three vote samples.
  localparam int          OVERSAMPLE    = 16;
  localparam logic [3:0]  HALF_BIT      = 4'h7;
  localparam logic [3:0]  LAST_TICK     = 4'hf;
  // The last vote sample is the live line at the shift tick.
  localparam logic [3:0]  VOTE_A        = 4'hd;
  localparam logic [3:0]  VOTE_B        = 4'he;
  localparam logic [3:0]  VOTE_C        = 4'hf;
  localparam int          FIFO_DEPTH    = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_e;

  typedef struct packed {
    logic       frameErr;
    logic [8:0] data;
  } rx_entry_s;

endpackage

// ==== design/rx_char_fifo.sv ====
`timescale 1ns/1ps
module rx_char_fifo
  import uart_rx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic      core_clk,
  input  wire logic      rst_b,
  input  wire logic      flush,
  input  wire logic      push,
  input  rx_entry_s      pushEntry,
  input  wire logic      pop,
  output rx_entry_s      topEntry,
  output logic           notEmpty,
  output logic           full
);

  rx_entry_s               mem_ff [DEPTH];
  logic [$clog2(DEPTH):0]  count_ff;
  logic [$clog2(DEPTH)-1:0] rdPtr_ff;
  logic [$clog2(DEPTH)-1:0] wrPtr_ff;
  logic                    doPush;
  logic                    doPop;

  assign notEmpty = (count_ff != '0);
  assign full     = (count_ff == ($clog2(DEPTH)+1)'(DEPTH));
  assign doPush   = push && !full;
  assign doPop    = pop && notEmpty;
  assign topEntry = mem_ff[rdPtr_ff];

  always_ff @(posedge core_clk)
  begin
    if (doPush)
    begin
      mem_ff[wrPtr_ff] <= pushEntry;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_ff <= '0;
      rdPtr_ff <= '0;
      wrPtr_ff <= '0;
    end
    else if (flush)
    begin
      count_ff <= '0;
      rdPtr_ff <= '0;
      wrPtr_ff <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr_ff <= (wrPtr_ff == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (doPop)
      begin
        rdPtr_ff <= (rdPtr_ff == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
      end
      count_ff <= count_ff + {{$clog2(DEPTH){1'b0}}, doPush} - {{$clog2(DEPTH){1'b0}}, doPop};
    end
  end

endmodule // rx_char_fifo

// ==== sim/uart_rx_monitor.sv ====
`timescale 1ns/1ps
module uart_rx_monitor
  import uart_rx_pkg::*;
(
  input logic        core_clk,
  input logic        rst_b,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic        baudTick16,
  input logic        receivePinOe,
  input logic        transmitPinOe,
  input logic        transmitDirBit,
  input logic        transmitPortLatch,
  input logic        transmitSerialOut,
  input logic        transmitPinOut,
  input logic        receiveInterruptFlag,
  input logic        receiveIrq
);
  logic       portEn_ff;
  logic       rxEn_ff;
  logic [2:0] ie_ff;
  wire acc = psel && penable;
  wire wrAny = acc && pwrite;
  wire dataRd = acc && !pwrite && paddr == RX_DATA_OFF;
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      portEn_ff <= 1'b0;
      rxEn_ff <= 1'b0;
    end
    else if (wrAny && paddr == RX_STATUS_OFF)
    begin
      portEn_ff <= pwdata[PORTEN_POS];
      rxEn_ff <= pwdata[RXEN_POS];
    end
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ie_ff <= 3'h0;
    else if (wrAny && paddr == INT_CTRL_OFF)
      ie_ff <= pwdata[2:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence sOff2;
    !(rxEn_ff && portEn_ff) ##1 !(rxEn_ff && portEn_ff);
  endsequence
  AST_PREADY: assert property (pready == acc) else $error("pready mismatch");
  AST_SLVERR: assert property (acc |-> pslverr == (paddr > TX_STATUS_OFF || paddr[1:0] != 2'h0))
    else $error("pslverr mismatch");
  AST_RX_INPUT: assert property (!receivePinOe) else $error("receive pin driven");
  AST_TX_PORT: assert property (portEn_ff |-> transmitPinOe && transmitPinOut == transmitSerialOut)
    else $error("transmit pin not taken");
  AST_TX_GPIO: assert property (!portEn_ff |-> transmitPinOe == !transmitDirBit && transmitPinOut == transmitPortLatch)
    else $error("transmit pin not released");
  AST_IRQ: assert property (receiveIrq == (receiveInterruptFlag && ie_ff == 3'h7)) else $error("irq gating");
  AST_FLAG_OFF: assert property (sOff2 |-> !receiveInterruptFlag) else $error("flag while disabled");
  AST_FLAG_RISE: assert property ($rose(receiveInterruptFlag) |-> $past(baudTick16) || $past(wrAny))
    else $error("flag rose without push");
  AST_FLAG_FALL: assert property ($fell(receiveInterruptFlag) |-> $past(dataRd) || $past(wrAny))
    else $error("flag fell without read");
endmodule // uart_rx_monitor
bind uart_async_receiver uart_rx_monitor uart_rx_monitor_inst (.*);

// ==== sim/uart_line_model.sv ====
`timescale 1ns/1ps
module uart_line_model
(
  input  logic        core_clk,
  input  logic        rst_b,
  input  logic        baudTick16,
  input  logic        go,
  input  logic        glitch,
  input  logic [11:0] frame,
  input  logic [3:0]  len,
  output logic        line,
  output logic        busy
);
  logic [3:0] tick_ff;
  logic [3:0] bit_ff;
  logic       short_ff;
  // A short first bit models a noise pulse that only looks like a start bit.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy <= 1'b0;
      line <= 1'b1;
    end
    else if (go && !busy)
    begin
      busy <= 1'b1;
      line <= frame[0];
      tick_ff <= 4'h0;
      bit_ff <= 4'h0;
      short_ff <= glitch;
    end
    else if (busy && baudTick16)
    begin
      tick_ff <= tick_ff + 4'h1;
      if (tick_ff == 4'hf || (short_ff && bit_ff == 4'h0 && tick_ff == 4'h3))
      begin
        tick_ff <= 4'h0;
        bit_ff <= bit_ff + 4'h1;
        busy <= bit_ff + 4'h1 != len;
        line <= bit_ff + 4'h1 == len ? 1'b1 : frame[bit_ff+4'h1];
      end
    end
  end
endmodule // uart_line_model

// ==== sim/tb_uart_async_receiver.sv ====
`timescale 1ns/1ps
module tb_uart_async_receiver
  import uart_rx_pkg::*;
;
  logic        core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, baudTick16 = 0;
  logic        dir = 0, latch = 0, sout = 0, go = 0, glitch = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, line, busy, flag, irq;
  logic [11:0] frame = 12'hfff;
  logic [3:0]  len = 4'ha;
  logic [1:0]  tc = 0;
  logic [8:0]  c[3];
  int          n_fail = 0, n_checks = 0, seed = 32'h4b48569a;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    tc <= tc + 2'h1;
    baudTick16 <= tc == 2'h3;
    {dir, latch, sout} <= 3'($random(seed));
  end
  uart_async_receiver uart_async_receiver_inst (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .baudTick16(baudTick16), .receivePinIn(line), .receivePinOe(), .transmitPinOe(), .transmitDirBit(dir),
    .transmitPortLatch(latch), .transmitSerialOut(sout), .transmitPinOut(), .receiveInterruptFlag(flag),
    .receiveIrq(irq));
  uart_line_model uart_line_model_inst (.core_clk(core_clk), .rst_b(rst_b), .baudTick16(baudTick16), .go(go),
    .glitch(glitch), .frame(frame), .len(len), .line(line), .busy(busy));
  function logic [31:0] st(logic [7:0] ctl, logic fl, fe, ov, n9);
    st = {23'h0, fl, ctl};
    st[FRAME_POS] = fe;
    st[OVERRUN_POS] = ov;
    st[NINTH_POS] = n9;
  endfunction
  task results;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, e);
    apb(0, a, 0);
    n_checks++;
    if ((q & m) !== e)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, q & m, e);
      n_fail++;
    end
  endtask
  task send(input logic [8:0] d, input logic n9, stp, gl);
    @(posedge core_clk);
    frame <= n9 ? {1'b1, stp, d, 1'b0} : {2'b11, stp, d[7:0], 1'b0};
    len <= n9 ? 4'hb : 4'ha;
    glitch <= gl;
    go <= 1;
    repeat (2) @(posedge core_clk);
    go <= 0;
    while (busy !== 1'b0) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1;
    rd(RX_STATUS_OFF, '1, RX_STATUS_RST);
    rd(INT_CTRL_OFF, '1, INT_CTRL_RST);
    rd(TX_STATUS_OFF, '1, TX_STATUS_RST);
    rd(8'h20, '1, 0);
    apb(1, INT_CTRL_OFF, 32'($random(seed)) & 32'h7);
    apb(1, RX_STATUS_OFF, 32'h90);
    foreach (c[i]) c[i] = 9'($random(seed)) & 9'hff;
    c[2] = 9'h0ff;
    send(c[0], 0, 1, 0);
    send(c[1], 0, 0, 0);
    send(c[2], 0, 1, 0);
    apb(1, INT_CTRL_OFF, 32'h7);
    rd(RX_STATUS_OFF, '1, st(8'h90, 1, 0, 1, 0));
    rd(RX_DATA_OFF, 32'hff, 32'(c[0][7:0]));
    rd(RX_STATUS_OFF, '1, st(8'h90, 1, 1, 1, 0));
    rd(RX_DATA_OFF, 32'hff, 32'(c[1][7:0]));
    rd(RX_STATUS_OFF, 32'h1fb, st(8'h90, 0, 0, 1, 0));
    apb(1, RX_STATUS_OFF, 32'h80);
    apb(1, RX_STATUS_OFF, 32'h90);
    rd(RX_STATUS_OFF, 32'h1fb, 32'h90);
    send(9'h0ff, 0, 1, 1);
    rd(RX_STATUS_OFF, 32'h1fb, 32'h90);
    send(9'h0a5, 0, 0, 0);
    send(c[0], 0, 1, 0);
    apb(1, RX_STATUS_OFF, 32'h80);
    rd(RX_STATUS_OFF, '1, st(8'h80, 0, 1, 0, 0));
    apb(1, RX_STATUS_OFF, 32'h90);
    rd(RX_DATA_OFF, 32'hff, 32'ha5);
    rd(RX_STATUS_OFF, '1, st(8'h90, 1, 0, 0, 0));
    rd(RX_DATA_OFF, 32'hff, 32'(c[0][7:0]));
    send(9'h03c, 0, 0, 0);
    apb(1, RX_STATUS_OFF, 32'h0);
    apb(1, RX_STATUS_OFF, 32'h90);
    rd(RX_STATUS_OFF, '1, 32'h90);
    apb(1, TX_STATUS_OFF, 32'h1 << SYNC_POS);
    send(9'h066, 0, 1, 0);
    rd(RX_STATUS_OFF, 32'h1fb, 32'h90);
    apb(1, TX_STATUS_OFF, 32'h0);
    apb(1, RX_STATUS_OFF, 32'hd8);
    send(9'h055, 1, 1, 0);
    send(9'h1aa, 1, 1, 0);
    rd(RX_STATUS_OFF, '1, st(8'hd8, 1, 0, 0, 1));
    rd(RX_DATA_OFF, 32'hff, 32'haa);
    apb(1, RX_STATUS_OFF, 32'hd0);
    send(9'h033, 1, 1, 0);
    rd(RX_DATA_OFF, 32'hff, 32'h33);
    results;
  end
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    results;
  end
endmodule // tb_uart_async_receiver
